// file: hw/pscs_pkg.sv
// Package: constants and carriers for the PHY special control/status register block
package pscs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed index 27 is not a multiple of four, so byte address is index * 4
  localparam logic [7:0] REG_IDX_SPECIAL_CTRL_STAT = 8'h1B;
  localparam logic [11:0] ADDR_SPECIAL_CTRL_STAT = 12'h06C;
  localparam logic [11:0] ADDR_PORT_RESET = 12'h070;
  localparam int REG_WIDTH = 16;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_XOVER_SRC = 15;
  localparam int BIT_XOVER_AUTO = 14;
  localparam int BIT_XOVER_STATE = 13;
  localparam int BIT_SQE_DIS = 11;
  localparam int BIT_PLL_FORCE = 10;
  localparam int BIT_POLARITY = 4;
  localparam int BIT_SOFT_RESET = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_XOVER_SRC = 1'h0;
  localparam logic RST_XOVER_AUTO = 1'h0;
  localparam logic RST_XOVER_STATE = 1'h0;
  localparam logic RST_SQE_DIS = 1'h0;
  localparam logic RST_PLL_FORCE = 1'h0;
  localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;

  typedef struct packed {
    logic source_select;
    logic auto_enable;
    logic manual_state;
    logic heartbeat_test_disable;
    logic rx_pll_force_reference;
  } pscs_ctrl_t;

  typedef struct packed {
    logic auto_enable;
    logic manual_state;
  } pscs_xover_t;
endpackage

// file: hw/pscs_top.sv
// Module: PHY special control/status register with APB slave and crossover source mux
// Operation
// - Sixteen-bit register at management index 27.
// - Source bit 15 set overrides straps; bits 14 and 13 drive crossover.
// - Source bit clear (reset 0) uses latched crossover straps.
// - Under override, bits 14 and 13 select crossover; both reset to 0.
// - Bit 11 written 1 disables heartbeat test; resets to 0.
// - Bit 10 set holds receive PLL on reference clock.
// - With PLL forced, 10M receive is blocked.
// - Read-only polarity status: 0 normal, 1 reversed.
// - Control bits return to defaults on per-port PHY soft reset.
`timescale 1ns/1ps
`default_nettype none
module pscs_top (
  input wire logic CORE_CLK, // 10 MHz clock
  input wire logic ARST_N, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic PHY_SOFT_RESET, // Per-port PHY soft reset pulse, same clock
  input wire logic STRAP_MANUAL_XOVER, // Manual crossover strap pin
  input wire logic STRAP_AUTO_XOVER, // Auto crossover strap pin
  input wire logic POLARITY_REVERSED, // Detected 10BASE-T polarity pin
  output logic XOVER_AUTO_ENABLE, // Effective auto crossover enable
  output logic XOVER_MANUAL_STATE, // Effective manual crossover state
  output logic HEARTBEAT_TEST_DISABLE, // Heartbeat test disabled
  output logic RX_PLL_FORCE_REFERENCE, // Receive PLL forced to reference
  output logic RX_10M_BLOCKED // 10M receive unavailable
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction

  logic setup_ph;
  logic wr_reg;
  logic wr_rst;
  logic mapped;
  assign setup_ph = PSEL & PENABLE;
  assign mapped = hit(PADDR, pscs_pkg::ADDR_SPECIAL_CTRL_STAT) | hit(PADDR, pscs_pkg::ADDR_PORT_RESET);
  assign wr_reg = setup_ph & PWRITE & hit(PADDR, pscs_pkg::ADDR_SPECIAL_CTRL_STAT);
  assign wr_rst = setup_ph & PWRITE & hit(PADDR, pscs_pkg::ADDR_PORT_RESET)
                  & PWDATA[pscs_pkg::BIT_SOFT_RESET];
  // Zero-wait slave: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = setup_ph & ~mapped;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] man_sync_ff;
  logic [2:0] auto_sync_ff;
  logic [2:0] pol_sync_ff;
  logic man_ff;
  logic auto_ff;
  logic pol_ff;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      man_sync_ff <= 3'h0;
      auto_sync_ff <= 3'h0;
      pol_sync_ff <= 3'h0;
    end else begin
      man_sync_ff <= {man_sync_ff[1:0], STRAP_MANUAL_XOVER};
      auto_sync_ff <= {auto_sync_ff[1:0], STRAP_AUTO_XOVER};
      pol_sync_ff <= {pol_sync_ff[1:0], POLARITY_REVERSED};
    end
  end

  // Change accepted only when stages two and three agree
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pol_ff <= 1'b0;
    end else if (pol_sync_ff[1] == pol_sync_ff[2]) begin
      pol_ff <= pol_sync_ff[2];
    end
  end

  // ----------------------------------------------------------------
  // Strap latch
  // ----------------------------------------------------------------
  // Straps are caught once after reset release, after the synchroniser settles
  logic [1:0] settle_ff;
  logic latched_ff;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      settle_ff <= 2'h0;
      latched_ff <= 1'b0;
      man_ff <= 1'b0;
      auto_ff <= 1'b0;
    end else if (!latched_ff) begin
      if (settle_ff == 2'h3) begin
        latched_ff <= 1'b1;
        man_ff <= man_sync_ff[2];
        auto_ff <= auto_sync_ff[2];
      end else begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  pscs_pkg::pscs_ctrl_t ctrl_ff;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= '{pscs_pkg::RST_XOVER_SRC, pscs_pkg::RST_XOVER_AUTO, pscs_pkg::RST_XOVER_STATE,
                   pscs_pkg::RST_SQE_DIS, pscs_pkg::RST_PLL_FORCE};
    end else if (PHY_SOFT_RESET || wr_rst) begin
      ctrl_ff <= '{pscs_pkg::RST_XOVER_SRC, pscs_pkg::RST_XOVER_AUTO, pscs_pkg::RST_XOVER_STATE,
                   pscs_pkg::RST_SQE_DIS, pscs_pkg::RST_PLL_FORCE};
    end else if (wr_reg) begin
      ctrl_ff.source_select <= PWDATA[pscs_pkg::BIT_XOVER_SRC];
      ctrl_ff.auto_enable <= PWDATA[pscs_pkg::BIT_XOVER_AUTO];
      ctrl_ff.manual_state <= PWDATA[pscs_pkg::BIT_XOVER_STATE];
      ctrl_ff.heartbeat_test_disable <= PWDATA[pscs_pkg::BIT_SQE_DIS];
      ctrl_ff.rx_pll_force_reference <= PWDATA[pscs_pkg::BIT_PLL_FORCE];
    end
  end

  // ----------------------------------------------------------------
  // Crossover source and outputs
  // ----------------------------------------------------------------
  pscs_pkg::pscs_xover_t xover_ff;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      xover_ff <= '0;
    end else if (ctrl_ff.source_select) begin
      xover_ff <= '{ctrl_ff.auto_enable, ctrl_ff.manual_state};
    end else begin
      xover_ff <= '{auto_ff, man_ff};
    end
  end
  assign XOVER_AUTO_ENABLE = xover_ff.auto_enable;
  assign XOVER_MANUAL_STATE = xover_ff.manual_state;
  assign HEARTBEAT_TEST_DISABLE = ctrl_ff.heartbeat_test_disable;
  assign RX_PLL_FORCE_REFERENCE = ctrl_ff.rx_pll_force_reference;
  assign RX_10M_BLOCKED = ctrl_ff.rx_pll_force_reference;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  always_comb begin
    nxt_rdata = pscs_pkg::APB_ERR_DATA;
    if (PSEL && !PENABLE && !PWRITE && hit(PADDR, pscs_pkg::ADDR_SPECIAL_CTRL_STAT)) begin
      nxt_rdata[pscs_pkg::BIT_XOVER_SRC] = ctrl_ff.source_select;
      nxt_rdata[pscs_pkg::BIT_XOVER_AUTO] = ctrl_ff.auto_enable;
      nxt_rdata[pscs_pkg::BIT_XOVER_STATE] = ctrl_ff.manual_state;
      nxt_rdata[pscs_pkg::BIT_SQE_DIS] = ctrl_ff.heartbeat_test_disable;
      nxt_rdata[pscs_pkg::BIT_PLL_FORCE] = ctrl_ff.rx_pll_force_reference;
      nxt_rdata[pscs_pkg::BIT_POLARITY] = pol_ff;
      // Bits 12 and 9..5 stay zero
    end
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign PRDATA = rdata_ff;
endmodule
`default_nettype wire

// file: sim/pscs_assertions.sv
// Checker: timing properties of the special control/status register block
`timescale 1ns/1ps
`default_nettype none
module pscs_assertions (
  input wire logic CORE_CLK, ARST_N, PSEL, PENABLE, PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  input wire logic PREADY, PSLVERR, PHY_SOFT_RESET, XOVER_AUTO_ENABLE, XOVER_MANUAL_STATE,
  input wire logic HEARTBEAT_TEST_DISABLE, RX_PLL_FORCE_REFERENCE, RX_10M_BLOCKED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire logic acc = PSEL && PENABLE;
  wire logic hit = PADDR == pscs_pkg::ADDR_SPECIAL_CTRL_STAT;
  // Soft reset wins over a write, so exclude it
  wire logic wr = acc && PWRITE && hit && !PHY_SOFT_RESET;
  wire logic rd = acc && !PWRITE && hit;
  ready_const_a: assert property (PREADY) else $error("ready low");
  slverr_map_a: assert property (acc |-> PSLVERR == (!hit && PADDR != pscs_pkg::ADDR_PORT_RESET))
    else $error("error response wrong");
  reserved_zero_a: assert property (rd |-> (PRDATA & 32'hFFFF_13E0) == 32'h0000_0000)
    else $error("reserved bits not zero");
  heartbeat_wr_a: assert property (wr |=> HEARTBEAT_TEST_DISABLE == $past(PWDATA[11]))
    else $error("heartbeat output wrong");
  pll_wr_a: assert property (wr |=> RX_PLL_FORCE_REFERENCE == $past(PWDATA[10]))
    else $error("pll output wrong");
  pll_block_a: assert property (RX_10M_BLOCKED == RX_PLL_FORCE_REFERENCE)
    else $error("receive block wrong");
  xover_override_a: assert property (wr && PWDATA[15] |-> ##2
    XOVER_AUTO_ENABLE == $past(PWDATA[14], 2) && XOVER_MANUAL_STATE == $past(PWDATA[13], 2))
    else $error("crossover override wrong");
  soft_reset_a: assert property (PHY_SOFT_RESET |=> !HEARTBEAT_TEST_DISABLE && !RX_PLL_FORCE_REFERENCE)
    else $error("soft reset left bits set");
  read_state_a: assert property (rd |-> PRDATA[11:10] == {HEARTBEAT_TEST_DISABLE, RX_PLL_FORCE_REFERENCE})
    else $error("read data disagrees");
  cover property (wr && PWDATA[15]);
  cover property (acc && PSLVERR);
  cover property (PHY_SOFT_RESET);
endmodule
bind pscs_top pscs_assertions pscs_assertions_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PHY_SOFT_RESET(PHY_SOFT_RESET), .XOVER_AUTO_ENABLE(XOVER_AUTO_ENABLE),
  .XOVER_MANUAL_STATE(XOVER_MANUAL_STATE), .HEARTBEAT_TEST_DISABLE(HEARTBEAT_TEST_DISABLE),
  .RX_PLL_FORCE_REFERENCE(RX_PLL_FORCE_REFERENCE), .RX_10M_BLOCKED(RX_10M_BLOCKED));
`default_nettype wire

// file: sim/testbench.sv
// Testbench: APB scoreboard for the special control/status register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CORE_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PHY_SOFT_RESET = 0;
  logic STRAP_MANUAL_XOVER = 0, STRAP_AUTO_XOVER = 0, POLARITY_REVERSED = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, d;
  logic PREADY, PSLVERR, XOVER_AUTO_ENABLE, XOVER_MANUAL_STATE;
  logic HEARTBEAT_TEST_DISABLE, RX_PLL_FORCE_REFERENCE, RX_10M_BLOCKED;
  logic [32:0] exp_q[$];
  int n_fail = 0, check_count = 0, seed = 80761;
  localparam logic [11:0] A = pscs_pkg::ADDR_SPECIAL_CTRL_STAT;
  always #50 CORE_CLK = ~CORE_CLK;
  pscs_top pscs_top_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PHY_SOFT_RESET(PHY_SOFT_RESET), .STRAP_MANUAL_XOVER(STRAP_MANUAL_XOVER),
    .STRAP_AUTO_XOVER(STRAP_AUTO_XOVER), .POLARITY_REVERSED(POLARITY_REVERSED),
    .XOVER_AUTO_ENABLE(XOVER_AUTO_ENABLE), .XOVER_MANUAL_STATE(XOVER_MANUAL_STATE),
    .HEARTBEAT_TEST_DISABLE(HEARTBEAT_TEST_DISABLE), .RX_PLL_FORCE_REFERENCE(RX_PLL_FORCE_REFERENCE),
    .RX_10M_BLOCKED(RX_10M_BLOCKED));
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    check_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Expected read word: live bits kept, reserved bits zero
  function automatic logic [32:0] rv(input logic [15:0] c);
    rv = {17'h0, c[15:13], 1'b0, c[11:10], 5'h0, POLARITY_REVERSED, 4'h0};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic [32:0] e);
    int n;
    @(posedge CORE_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, dat};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    // Note queued before the access edge so the monitor never runs ahead
    if (!w) exp_q.push_back(e);
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      tally_and_finish();
    end else begin
      {PSEL, PENABLE} <= 2'h0;
    end
  endtask
  task automatic outs(input logic [4:0] e);
    #1 chk("outputs", {28'h0, XOVER_AUTO_ENABLE, XOVER_MANUAL_STATE, HEARTBEAT_TEST_DISABLE,
      RX_PLL_FORCE_REFERENCE, RX_10M_BLOCKED}, {28'h0, e});
  endtask
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("wrong value read note expected queued seen none");
      end else chk("read", {PSLVERR, PRDATA}, exp_q.pop_front());
    end
  end
  initial begin
    {STRAP_AUTO_XOVER, STRAP_MANUAL_XOVER, POLARITY_REVERSED} = 3'($random(seed));
    repeat (8) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    repeat (12) @(posedge CORE_CLK);
    outs({STRAP_AUTO_XOVER, STRAP_MANUAL_XOVER, 3'h0});
    apb(1'b0, A, 32'h0, rv(16'h0));
    for (int i = 0; i < 4; i++) begin
      d = $random(seed) | 32'h0000_93E0;
      d[14:13] = i[1:0];
      apb(1'b1, A, d, 33'h0);
      apb(1'b0, A, 32'h0, rv(d[15:0]));
      outs({d[14:13], d[11:10], d[10]});
    end
    d = 32'h0000_6C00;
    apb(1'b1, A, d, 33'h0);
    repeat (2) @(posedge CORE_CLK);
    outs({STRAP_AUTO_XOVER, STRAP_MANUAL_XOVER, 3'h7});
    apb(1'b1, 12'h0F0, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, 12'h0F0, 32'h0, {1'b1, 32'h0});
    apb(1'b0, A, 32'h0, rv(d[15:0]));
    @(posedge CORE_CLK) PHY_SOFT_RESET <= 1'b1;
    @(posedge CORE_CLK) PHY_SOFT_RESET <= 1'b0;
    apb(1'b0, A, 32'h0, rv(16'h0));
    apb(1'b1, A, 32'h0000_EC00, 33'h0);
    apb(1'b1, pscs_pkg::ADDR_PORT_RESET, 32'h1, 33'h0);
    apb(1'b0, A, 32'h0, rv(16'h0));
    outs({STRAP_AUTO_XOVER, STRAP_MANUAL_XOVER, 3'h0});
    @(posedge CORE_CLK) POLARITY_REVERSED <= ~POLARITY_REVERSED;
    repeat (6) @(posedge CORE_CLK);
    apb(1'b0, A, 32'h0, rv(16'h0));
    // Mid-run reset: control bits set first so the clear is visible
    apb(1'b1, A, 32'h0000_EC00, 33'h0);
    @(posedge CORE_CLK) ARST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    outs(5'h0);
    @(posedge CORE_CLK) ARST_N <= 1'b1;
    repeat (12) @(posedge CORE_CLK);
    outs({STRAP_AUTO_XOVER, STRAP_MANUAL_XOVER, 3'h0});
    apb(1'b0, A, 32'h0, rv(16'h0));
    repeat (2) @(posedge CORE_CLK);
    tally_and_finish();
  end
endmodule
`default_nettype wire
